// ---- rtl/tsn_defs.vh ----
// Constants for the TDM network mode serial port
`ifndef TSN_DEFS_VH
`define TSN_DEFS_VH

// Register addresses (4-bit address port)
`define TSN_ADDR_CTRL      4'h0
`define TSN_ADDR_STATUS    4'h1
`define TSN_ADDR_TX_DATA   4'h2
`define TSN_ADDR_TX_SLOT   4'h3
`define TSN_ADDR_RX_DATA   4'h4
`define TSN_ADDR_FRAME     4'h5

// Control register fields
`define TSN_CTRL_PORT_EN   0
`define TSN_CTRL_TX_EN     1
`define TSN_CTRL_RX_EN     2
`define TSN_CTRL_SHARED    3
`define TSN_CTRL_TX_IE     4
`define TSN_CTRL_RX_IE     5
`define TSN_CTRL_RESET     8'h00

// Status register fields
`define TSN_ST_TX_EMPTY    0
`define TSN_ST_TX_UNDER    1
`define TSN_ST_RX_READY    2
`define TSN_ST_RX_OVER     3
`define TSN_ST_TX_FRAME    4
`define TSN_ST_RX_FRAME    5

// Word length in bits and slots in a frame
`define TSN_WORD_BITS      8
`define TSN_BIT_CNT_W      3
`define TSN_SLOTS_RESET    8'h05

`endif

// ---- rtl/tsn_port.v ----
// TDM network mode synchronous serial port, transmit and receive halves
//
// Overview of operation
// - Clearing tx_enable tri-states the transmit data pin at once, mid-word.
// - Setting tx_enable again resumes transmission at the next frame sync.
// - While tx_enable is zero the transmit data pin is not driven.
// - A transmit interrupt request is raised for every time slot.
// - Data write sends next slot; slot register write tri-states next slot.
// - No write in a slot: underrun flagged, previous word resent.
// - Receiver runs with port and rx enable, starting at a frame boundary.
// - Receiver captures every slot; software discards unwanted slots.
// - Receive frame timing starts at the rising edge of frame sync.
// - Receive data sampled on falling bit clock edge into shift register.
// - At each word boundary the shift register is copied to rx data.
// - Receive ready flag sets at every word boundary.
// - Ready raises rx interrupt when enabled; reading rx data clears it.
// - Unread rx data at end of slot raises receive overrun.
// - Shared clocking select makes receiver use transmit clock and sync.
// - Separate receive and transmit interrupt requests are provided.
// - Synchronous rx interrupt comes half a bit before tx data use.
// - Empty flag sets at each word start, cleared by either tx write.
// - Active slots shift one bit per rising tx clock; inactive tri-state.
`include "tsn_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module tsn_port (
    input  wire       i_ref_clk,
    input  wire       i_rst,
    input  wire       i_clk_en,
    input  wire [3:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    output reg  [7:0] o_rdata,
    input  wire       i_tx_bit_clock,
    input  wire       i_tx_frame_sync,
    input  wire       i_rx_bit_clock,
    input  wire       i_rx_frame_sync,
    input  wire       i_rx_data_pin,
    output reg        o_tx_data_pin,
    output reg        o_tx_data_oe,
    output reg        o_tx_irq,
    output reg        o_rx_irq
);

    // ****************************************************************
    // Pin synchronisers: three stages, change counts when 2 and 3 agree
    // ****************************************************************
    reg [2:0] tck_sync_reg;
    reg [2:0] tfs_sync_reg;
    reg [2:0] rck_sync_reg;
    reg [2:0] rfs_sync_reg;
    reg [2:0] rxd_sync_reg;
    reg       tck_reg;
    reg       tfs_reg;
    reg       rck_reg;
    reg       rfs_reg;
    reg       rxd_reg;

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            tck_sync_reg <= 3'h0;
            tfs_sync_reg <= 3'h0;
            rck_sync_reg <= 3'h0;
            rfs_sync_reg <= 3'h0;
            rxd_sync_reg <= 3'h0;
            tck_reg      <= 1'b0;
            tfs_reg      <= 1'b0;
            rck_reg      <= 1'b0;
            rfs_reg      <= 1'b0;
            rxd_reg      <= 1'b0;
        end else if (i_clk_en) begin
            tck_sync_reg <= {tck_sync_reg[1:0], i_tx_bit_clock};
            tfs_sync_reg <= {tfs_sync_reg[1:0], i_tx_frame_sync};
            rck_sync_reg <= {rck_sync_reg[1:0], i_rx_bit_clock};
            rfs_sync_reg <= {rfs_sync_reg[1:0], i_rx_frame_sync};
            rxd_sync_reg <= {rxd_sync_reg[1:0], i_rx_data_pin};
            if (tck_sync_reg[1] == tck_sync_reg[2])
                tck_reg <= tck_sync_reg[2];
            if (tfs_sync_reg[1] == tfs_sync_reg[2])
                tfs_reg <= tfs_sync_reg[2];
            if (rck_sync_reg[1] == rck_sync_reg[2])
                rck_reg <= rck_sync_reg[2];
            if (rfs_sync_reg[1] == rfs_sync_reg[2])
                rfs_reg <= rfs_sync_reg[2];
            if (rxd_sync_reg[1] == rxd_sync_reg[2])
                rxd_reg <= rxd_sync_reg[2];
        end
    end

    // ****************************************************************
    // Edge detection and clock selection
    // ****************************************************************
    reg  [7:0] ctrl_reg;
    reg        tck_q_reg;
    reg        tfs_q_reg;
    reg        rck_q_reg;
    reg        rfs_q_reg;

    wire port_en   = ctrl_reg[`TSN_CTRL_PORT_EN];
    wire tx_enable = ctrl_reg[`TSN_CTRL_TX_EN];
    wire rx_enable = ctrl_reg[`TSN_CTRL_RX_EN];
    wire shared    = ctrl_reg[`TSN_CTRL_SHARED];

    wire tck_rise  = tck_reg & ~tck_q_reg;
    wire tfs_rise  = tfs_reg & ~tfs_q_reg;
    // Receiver follows the transmitter's clock and sync when shared
    wire rck_now   = shared ? tck_reg : rck_reg;
    wire rck_prev  = shared ? tck_q_reg : rck_q_reg;
    wire rfs_now   = shared ? tfs_reg : rfs_reg;
    wire rfs_prev  = shared ? tfs_q_reg : rfs_q_reg;
    wire rck_fall  = ~rck_now & rck_prev;
    wire rfs_rise  = rfs_now & ~rfs_prev;

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            tck_q_reg <= 1'b0;
            tfs_q_reg <= 1'b0;
            rck_q_reg <= 1'b0;
            rfs_q_reg <= 1'b0;
        end else if (i_clk_en) begin
            tck_q_reg <= tck_reg;
            tfs_q_reg <= tfs_reg;
            rck_q_reg <= rck_reg;
            rfs_q_reg <= rfs_reg;
        end
    end

    // ****************************************************************
    // Transmitter
    // ****************************************************************
    reg  [7:0] tx_data_reg;
    reg  [7:0] tx_shift_reg;
    reg  [2:0] tx_bit_reg;
    reg        tx_run_reg;
    reg        tx_active_reg;
    reg        tx_wrote_data_reg;
    reg        tx_wrote_slot_reg;
    reg        tx_empty_flag;
    reg        tx_underrun_flag;
    reg        tx_frame_start_flag;

    wire wr_ctrl  = i_wr & (i_addr == `TSN_ADDR_CTRL);
    wire wr_stat  = i_wr & (i_addr == `TSN_ADDR_STATUS);
    wire wr_txd   = i_wr & (i_addr == `TSN_ADDR_TX_DATA);
    wire wr_slot  = i_wr & (i_addr == `TSN_ADDR_TX_SLOT);
    wire rd_rxd   = i_rd & (i_addr == `TSN_ADDR_RX_DATA);
    // Word boundary: frame sync rise, or bit counter wrapping mid-frame
    wire tx_last  = (tx_bit_reg == 3'h7);
    wire tx_word  = tck_rise & (tfs_rise | (tx_run_reg & tx_last));

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_data_reg         <= 8'h00;
            tx_shift_reg        <= 8'h00;
            tx_bit_reg          <= 3'h0;
            tx_run_reg          <= 1'b0;
            tx_active_reg       <= 1'b0;
            tx_wrote_data_reg   <= 1'b0;
            tx_wrote_slot_reg   <= 1'b0;
            tx_empty_flag       <= 1'b0;
            tx_underrun_flag    <= 1'b0;
            tx_frame_start_flag <= 1'b0;
            o_tx_data_pin       <= 1'b0;
            o_tx_data_oe        <= 1'b0;
            o_tx_irq            <= 1'b0;
        end else if (i_clk_en) begin
            if (wr_txd)
                tx_data_reg <= i_wdata;
            if (wr_txd)
                tx_wrote_data_reg <= 1'b1;
            if (wr_slot)
                tx_wrote_slot_reg <= 1'b1;
            if (wr_txd | wr_slot)
                tx_empty_flag <= 1'b0;
            if (wr_stat & i_wdata[`TSN_ST_TX_UNDER])
                tx_underrun_flag <= 1'b0;
            if (wr_stat & i_wdata[`TSN_ST_TX_FRAME])
                tx_frame_start_flag <= 1'b0;
            if (tck_rise & tfs_rise)
                tx_frame_start_flag <= 1'b1;
            if (tck_rise) begin
                tx_bit_reg <= tx_word ? 3'h0 : tx_bit_reg + 3'h1;
                if (!tx_word)
                    tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
            if (tx_word) begin
                tx_run_reg <= 1'b1;
                tx_wrote_data_reg <= 1'b0;
                tx_wrote_slot_reg <= 1'b0;
                // Disable clears tx_active_reg only here; the pin enable drops at once
                if (port_en & tx_enable & (tx_run_reg | tfs_rise)) begin
                    tx_empty_flag <= 1'b1;
                    if (tx_wrote_slot_reg) begin
                        tx_active_reg <= 1'b0;
                    end else begin
                        // Missing write reuses old data on a driven slot
                        if (!tx_wrote_data_reg)
                            tx_underrun_flag <= 1'b1;
                        tx_active_reg <= 1'b1;
                        tx_shift_reg  <= tx_data_reg;
                    end
                end else begin
                    tx_active_reg <= 1'b0;
                end
            end
            if (!(port_en & tx_enable) & !tx_active_reg)
                tx_run_reg <= 1'b0;
            o_tx_data_pin <= tx_shift_reg[7];
            o_tx_data_oe  <= tx_active_reg & tx_enable;
            o_tx_irq      <= tx_empty_flag & ctrl_reg[`TSN_CTRL_TX_IE];
        end
    end

    // ****************************************************************
    // Receiver
    // ****************************************************************
    reg  [7:0] rx_shift_reg;
    reg  [7:0] rx_data_reg;
    reg  [2:0] rx_bit_reg;
    reg        rx_run_reg;
    reg        rx_ready_flag;
    reg        rx_overrun_flag;
    reg        rx_frame_start_flag;

    wire rx_on   = port_en & rx_enable;
    wire rx_last = (rx_bit_reg == 3'h7);

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_shift_reg        <= 8'h00;
            rx_data_reg         <= 8'h00;
            rx_bit_reg          <= 3'h0;
            rx_run_reg          <= 1'b0;
            rx_ready_flag       <= 1'b0;
            rx_overrun_flag     <= 1'b0;
            rx_frame_start_flag <= 1'b0;
            o_rx_irq            <= 1'b0;
        end else if (i_clk_en) begin
            if (rd_rxd)
                rx_ready_flag <= 1'b0;
            if (wr_stat & i_wdata[`TSN_ST_RX_OVER])
                rx_overrun_flag <= 1'b0;
            if (wr_stat & i_wdata[`TSN_ST_RX_FRAME])
                rx_frame_start_flag <= 1'b0;
            if (rfs_rise)
                rx_frame_start_flag <= 1'b1;
            if (!rx_on) begin
                rx_run_reg <= 1'b0;
            end else if (rfs_rise) begin
                rx_run_reg <= 1'b1;
                rx_bit_reg <= 3'h0;
            end
            // Every slot is captured; software picks the wanted ones
            if (rck_fall & rx_run_reg & rx_on) begin
                rx_shift_reg <= {rx_shift_reg[6:0], rxd_reg};
                rx_bit_reg   <= rx_bit_reg + 3'h1;
                if (rx_last) begin
                    rx_data_reg   <= {rx_shift_reg[6:0], rxd_reg};
                    rx_ready_flag <= 1'b1;
                    // Falling-edge transfer leads tx use by half a bit
                    if (rx_ready_flag & !rd_rxd)
                        rx_overrun_flag <= 1'b1;
                end
            end
            o_rx_irq <= rx_ready_flag & ctrl_reg[`TSN_CTRL_RX_IE];
        end
    end

    // ****************************************************************
    // Register port
    // ****************************************************************
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_reg <= `TSN_CTRL_RESET;
            o_rdata  <= 8'h00;
        end else if (i_clk_en) begin
            if (wr_ctrl)
                ctrl_reg <= i_wdata;
            o_rdata <= 8'h00;
            if (i_rd) begin
                case (i_addr)
                    `TSN_ADDR_CTRL:    o_rdata <= ctrl_reg;
                    `TSN_ADDR_STATUS:  o_rdata <= {2'h0,
                        rx_frame_start_flag, tx_frame_start_flag,
                        rx_overrun_flag, rx_ready_flag,
                        tx_underrun_flag, tx_empty_flag};
                    `TSN_ADDR_TX_DATA: o_rdata <= tx_data_reg;
                    `TSN_ADDR_RX_DATA: o_rdata <= rx_data_reg;
                    `TSN_ADDR_FRAME:   o_rdata <= {5'h00, rx_bit_reg};
                    default:           o_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule // tsn_port

`default_nettype wire

// ---- tb/tsn_port_props.sv ----
// Concurrent checks on the TDM serial port pins and register bus
`include "tsn_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module tsn_port_props (
    input wire logic       i_ref_clk,
    input wire logic       i_rst,
    input wire logic       i_clk_en,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       i_tx_bit_clock,
    input wire logic       i_rx_bit_clock,
    input wire logic       o_tx_data_pin,
    input wire logic       o_tx_data_oe,
    input wire logic       o_tx_irq,
    input wire logic       o_rx_irq
);
    // ****
    // Helper state
    // ****
    logic [7:0] ctrl_q;
    logic       tx_clk_q;
    logic       rx_clk_q;
    logic [3:0] age;
    // Age since any link clock edge; tx data must not move, nor irqs rise without a write, on a still link
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q   <= 8'h00;
            tx_clk_q <= 1'b0;
            rx_clk_q <= 1'b0;
            age      <= 4'hf;
        end else begin
            tx_clk_q <= i_tx_bit_clock;
            rx_clk_q <= i_rx_bit_clock;
            if (i_clk_en && i_wr && i_addr == `TSN_ADDR_CTRL)
                ctrl_q <= i_wdata;
            if (tx_clk_q != i_tx_bit_clock || rx_clk_q != i_rx_bit_clock)
                age <= 4'h0;
            else if (age != 4'hf)
                age <= age + 4'h1;
        end
    end
    // ****
    // Properties
    // ****
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence rx_read_s;
        i_rd && i_addr == `TSN_ADDR_RX_DATA;
    endsequence
    sequence tx_write_s;
        i_wr && (i_addr == `TSN_ADDR_TX_DATA || i_addr == `TSN_ADDR_TX_SLOT);
    endsequence
    rx_read_clear_a: assert property (rx_read_s |-> ##2 !o_rx_irq)
        else $error("rx irq stayed up after data read");
    tx_write_clear_a: assert property (tx_write_s |-> ##2 !o_tx_irq)
        else $error("tx irq stayed up after tx write");
    tx_off_quiet_a: assert property (
        !ctrl_q[1] && !$past(ctrl_q[1]) |-> !o_tx_data_oe)
        else $error("tx pin driven while disabled");
    tx_data_clocked_a: assert property (
        $changed(o_tx_data_pin) |-> age < 4'hc)
        else $error("tx data moved without a link clock");
    tx_irq_clocked_a: assert property (
        $rose(o_tx_irq) && !$past(i_wr) && !$past(i_wr, 2) |-> age < 4'hc)
        else $error("tx irq rose without a word start");
    rx_irq_clocked_a: assert property (
        $rose(o_rx_irq) && !$past(i_wr) && !$past(i_wr, 2) |-> age < 4'hc)
        else $error("rx irq rose without a word end");
    rx_irq_enabled_a: assert property (
        $rose(o_rx_irq) |-> $past(ctrl_q[0] && ctrl_q[2]))
        else $error("rx irq while receiver disabled");
    ctrl_readback_a: assert property (
        i_rd && i_addr == `TSN_ADDR_CTRL |=> o_rdata[5:0] == ctrl_q[5:0])
        else $error("control read back differs");
endmodule // tsn_port_props
bind tsn_port tsn_port_props tsn_port_props_inst (.i_ref_clk, .i_rst,
    .i_clk_en,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_tx_bit_clock,
    .i_rx_bit_clock, .o_tx_data_pin, .o_tx_data_oe, .o_tx_irq, .o_rx_irq);
`default_nettype wire

// ---- tb/tsn_bus_model.sv ----
// Far side of the TDM bus: bit clock, frame sync, rx data, tx capture
`timescale 1ns/100ps
`default_nettype none
module tsn_bus_model (
    input  wire logic i_run,
    input  wire logic i_tx_data_pin,
    input  wire logic i_tx_data_oe,
    output logic      o_bit_clock,
    output logic      o_frame_sync,
    output logic      o_rx_data_pin
);
    // ****
    // Frame generator, 5 slots of 8 bits
    // ****
    logic [7:0] cap_word [0:4];
    logic       cap_oe [0:4];
    logic [7:0] sr = 8'h00;
    logic [7:0] rx_word;
    logic       active = 1'b0;
    int         slot = 0, rx_slot = 0, frames = -1, bitn;
    initial begin
        o_bit_clock = 1'b0;
        o_frame_sync = 1'b0;
        o_rx_data_pin = 1'b0;
        wait (i_run === 1'b1);
        #37;
        active = 1'b1;
        // Clock stands low until the run starts
        while (i_run === 1'b1) begin
            for (bitn = 0; bitn < 40; bitn++) begin
                // Sampled at the next rise, as the pin settles late
                // A released line has no pull, so it reads as garbage
                sr = {sr[6:0], i_tx_data_oe ? i_tx_data_pin : ~i_tx_data_pin};
                if (bitn % 8 == 0 && frames >= 0) begin
                    cap_word[(bitn / 8 + 4) % 5] = sr;
                    cap_oe[(bitn / 8 + 4) % 5] = i_tx_data_oe;
                end
                if (bitn == 0)
                    frames++;
                slot = bitn / 8;
                rx_word = 8'h5a + 8'(slot);
                o_frame_sync = (bitn == 0);
                o_rx_data_pin = rx_word[7 - bitn % 8];
                o_bit_clock = 1'b1;
                #200;
                o_bit_clock = 1'b0;
                if (bitn % 8 == 7)
                    rx_slot = slot;
                #200;
            end
        end
    end
endmodule // tsn_bus_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the TDM serial port
`include "tsn_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic       i_ref_clk;
    logic       i_rst;
    logic [3:0] i_addr;
    logic [7:0] i_wdata;
    logic       i_wr;
    logic       i_rd;
    logic       run;
    logic       clk_en;
    logic [7:0] d;
    wire  [7:0] o_rdata;
    wire        o_tx_data_pin, o_tx_data_oe, o_tx_irq, o_rx_irq;
    wire        bclk, fsync, rxd;
    int         n_errors = 0, checks = 0, tx_seen = -1, step = 0, nxt, j;
    tsn_port tsn_port_inst (.i_ref_clk, .i_rst, .i_clk_en(clk_en), .i_addr,
        .i_wdata, .i_wr, .i_rd, .o_rdata, .i_tx_bit_clock(bclk),
        .i_tx_frame_sync(fsync), .i_rx_bit_clock(bclk),
        .i_rx_frame_sync(fsync), .i_rx_data_pin(rxd), .o_tx_data_pin,
        .o_tx_data_oe, .o_tx_irq, .o_rx_irq);
    tsn_bus_model bm (.i_run(run), .i_tx_data_pin(o_tx_data_pin),
        .i_tx_data_oe(o_tx_data_oe), .o_bit_clock(bclk),
        .o_frame_sync(fsync), .o_rx_data_pin(rxd));
    // ****
    // Clock, tasks and watchdog
    // ****
    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        @(posedge i_ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
        @(posedge i_ref_clk);
    endtask
    task automatic check(input string nm, input logic [7:0] s, e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    function automatic logic [7:0] tx_val(input int k);
        return 8'hc0 + 8'(k);
    endfunction
    // Slot 1 tri-stated, slot 3 left unserved so it repeats slot 2
    task automatic check_frame;
        for (int k = 0; k < 5; k++) begin
            check("tx_oe", {7'h00, bm.cap_oe[k]}, 8'(k != 1));
            if (k != 1)
                check("tx_word", bm.cap_word[k], tx_val(k == 3 ? 2 : k));
        end
    endtask
    task automatic final_report;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #300000;
        n_errors++;
        final_report();
    end
    // ****
    // Main sequence
    // ****
    initial begin
        i_rst = 1'b1;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        run = 1'b0;
        clk_en = 1'b1;
        repeat (10) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        // A write while the clock enable is low must leave no trace
        clk_en <= 1'b0;
        wr(`TSN_ADDR_CTRL, 8'h3f);
        clk_en <= 1'b1;
        rd(`TSN_ADDR_CTRL, d);
        check("ctrl_reset", d, `TSN_CTRL_RESET);
        rd(4'hf, d);
        check("unmapped", d, 8'h00);
        wr(`TSN_ADDR_TX_DATA, tx_val(0));
        wr(`TSN_ADDR_CTRL, 8'h3f);
        run <= 1'b1;
        while (step < 3) begin
            @(posedge i_ref_clk);
            #1;
            if (bm.active && o_tx_irq === 1'b1
                && bm.frames * 5 + bm.slot != tx_seen) begin
                tx_seen = bm.frames * 5 + bm.slot;
                nxt = (bm.slot + 1) % 5;
                // An unserved slot keeps the flag up across the boundary;
                // answer only once the design has passed its word start
                repeat (8) @(posedge i_ref_clk);
                if (nxt == 1)
                    wr(`TSN_ADDR_TX_SLOT, 8'h00);
                else if (nxt != 3)
                    wr(`TSN_ADDR_TX_DATA, tx_val(nxt));
            end
            // Slot 3 is never read so that an overrun follows
            if (o_rx_irq === 1'b1 && bm.rx_slot != 3) begin
                // After the unread slot the flag never drops, so the
                // new word lands some cycles after the pin edge
                repeat (8) @(posedge i_ref_clk);
                rd(`TSN_ADDR_RX_DATA, d);
                check("rx_data", d, 8'h5a + 8'(bm.rx_slot));
            end
            if (bm.frames == 2 * step + 2) begin
                if (step == 1) begin
                    for (j = 0; j < 5; j++)
                        check("tx_off", {7'h00, bm.cap_oe[j]}, 8'h00);
                    wr(`TSN_ADDR_CTRL, 8'h37);
                end else
                    check_frame();
                if (step == 0) begin
                    rd(`TSN_ADDR_STATUS, d);
                    check("underrun", {7'h00, d[1]}, 8'h01);
                    check("overrun", {7'h00, d[3]}, 8'h01);
                    wr(`TSN_ADDR_CTRL, 8'h3d);
                end
                step++;
            end
        end
        final_report();
    end
endmodule // testbench
`default_nettype wire
